// file: design/gpio_pkg.sv
// Shared constants, bus carriers and state layout for the port I/O block
package gpio_pkg;
   localparam int unsigned NUM_PORTS = 6;
   localparam int unsigned PORT_W = 8;
   localparam int unsigned PIN_W = 48;
   localparam int unsigned NIB_W = 4;
   // Port indices inside the latch array
   localparam int unsigned PORT_TWO = 0;
   localparam int unsigned PORT_THREE = 1;
   localparam int unsigned FIRST_NIB_PORT = 2;
   // Register addresses in the special-function space
   localparam logic [7:0] ADDR_PORT_TWO = 8'hA0;
   localparam logic [7:0] ADDR_PORT_THREE = 8'hB0;
   localparam logic [7:0] ADDR_PORT_FOUR = 8'h84;
   localparam logic [7:0] ADDR_PORT_FIVE = 8'h85;
   localparam logic [7:0] ADDR_PORT_SIX = 8'h86;
   localparam logic [7:0] ADDR_PORT_SEVEN = 8'h87;
   localparam logic [7:0] ADDR_TWO_DRIVE = 8'hA6;
   localparam logic [7:0] ADDR_THREE_DRIVE = 8'hA7;
   localparam logic [7:0] ADDR_EDGE_FLAGS = 8'hAD;
   localparam logic [7:0] ADDR_NIB_DRIVE = 8'hB5;
   // Bit-addressable registers sit on addresses with these low bits clear
   localparam logic [2:0] BIT_ADDR_LOW = 3'h0;
   // Reset values
   localparam logic [7:0] LATCH_RST = 8'hFF;
   localparam logic [7:0] DRIVE_RST = 8'h00;
   localparam logic [1:0] PEND_RST = 2'h0;
   localparam logic [1:0] POL_RST = 2'h0;
   localparam logic [1:0] PREV_RST = 2'h3;
   localparam logic [7:0] RDATA_RST = 8'h00;
   // Edge flag register layout; index 0 is input six, index 1 is input seven
   localparam int unsigned PEND_SIX_BIT = 6;
   localparam int unsigned PEND_SEVEN_BIT = 7;
   localparam int unsigned POL_SIX_BIT = 2;
   localparam int unsigned POL_SEVEN_BIT = 3;
   // Pin positions of the two edge inputs (port three bits six and seven)
   localparam int unsigned PIN_EDGE_SIX = 14;
   localparam int unsigned PIN_EDGE_SEVEN = 15;
   localparam int unsigned EXTERNAL_MEMORY_INTERFACE_HIGH_BYTE = 8;

   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic rmw;
      logic bit_en;
      logic [2:0] bit_sel;
      logic [7:0] wdata;
   } sfr_req_s;

   typedef struct packed {
      logic active;
      logic muxed;
      logic data_drive;
      logic [15:0] addr;
      logic [7:0] data;
   } external_memory_interface_s;

   typedef struct packed {
      logic [NUM_PORTS-1:0][7:0] latch;
      logic [7:0] two_drive;
      logic [7:0] three_drive;
      logic [7:0] nib_drive;
      logic [1:0] pend;
      logic [1:0] pol;
      logic [1:0] prev;
      logic [1:0] irq;
      logic [7:0] rdata;
      logic [PIN_W-1:0] pin_out;
      logic [PIN_W-1:0] pin_oe;
      logic [PIN_W-1:0] pullup_en;
   } port_state_s;
endpackage

// file: design/port_io_block.sv
// Port two to seven latches, drive modes, readback and port-three edge flags
module port_io_block
   import gpio_pkg::*;
(
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   // Special-function register access
   input wire sfr_req_s i_sfr,
   output logic [7:0] o_sfr_rdata,
   // Crossbar and memory interface controls
   input wire logic [PIN_W-1:0] i_force_open_drain,
   input wire logic i_pullup_global_disable,
   input wire external_memory_interface_s i_external_memory_interface,
   // Pins, port two in bits 7:0 up to port seven in bits 47:40
   input wire logic [PIN_W-1:0] i_pin_in,
   output logic [PIN_W-1:0] o_pin_out,
   output logic [PIN_W-1:0] o_pin_oe,
   output logic [PIN_W-1:0] o_pullup_en,
   // Requests toward the interrupt controller, index 0 is input six
   output logic [1:0] o_edge_irq
);

   port_state_s st_r;
   port_state_s st_nxt;

   function automatic logic [7:0] port_addr(input int unsigned k);
      logic [7:0] a;
      a = ADDR_PORT_SEVEN;
      if (k == 0) begin
         a = ADDR_PORT_TWO;
      end else if (k == 1) begin
         a = ADDR_PORT_THREE;
      end else if (k == 2) begin
         a = ADDR_PORT_FOUR;
      end else if (k == 3) begin
         a = ADDR_PORT_FIVE;
      end else if (k == 4) begin
         a = ADDR_PORT_SIX;
      end
      return a;
   endfunction

   function automatic logic bit_addressable(input logic [7:0] a);
      return a[2:0] == BIT_ADDR_LOW;
   endfunction

   // Push-pull select of one pin from the per-pin or per-nibble registers
   function automatic logic push_pull(input port_state_s s, input int unsigned k,
                                      input int unsigned b);
      logic pp;
      if (k == PORT_TWO) begin
         pp = s.two_drive[b];
      end else if (k == PORT_THREE) begin
         pp = s.three_drive[b];
      end else begin
         pp = s.nib_drive[(k - FIRST_NIB_PORT) * 2 + b / NIB_W];
      end
      return pp;
   endfunction

   logic byte_wr;
   logic bit_wr;
   assign byte_wr = i_sfr.wr && !i_sfr.bit_en;
   assign bit_wr = i_sfr.wr && i_sfr.bit_en && bit_addressable(i_sfr.addr);

   always_comb begin
      logic val;
      logic drv;
      logic edge_seen;
      logic pin_now;
      int unsigned p;
      val = 1'b0;
      drv = 1'b0;
      edge_seen = 1'b0;
      pin_now = 1'b0;
      p = 0;
      st_nxt = st_r;

      // Latch writes; nibble ports accept whole bytes only
      for (int unsigned k = 0; k < NUM_PORTS; k++) begin
         if (i_sfr.addr == port_addr(k)) begin
            if (byte_wr) begin
               st_nxt.latch[k] = i_sfr.wdata;
            end else if (bit_wr) begin
               st_nxt.latch[k][i_sfr.bit_sel] = i_sfr.wdata[0];
            end
         end
      end

      if (byte_wr) begin
         if (i_sfr.addr == ADDR_TWO_DRIVE) begin
            st_nxt.two_drive = i_sfr.wdata;
         end else if (i_sfr.addr == ADDR_THREE_DRIVE) begin
            st_nxt.three_drive = i_sfr.wdata;
         end else if (i_sfr.addr == ADDR_NIB_DRIVE) begin
            st_nxt.nib_drive = i_sfr.wdata;
         end else if (i_sfr.addr == ADDR_EDGE_FLAGS) begin
            // Only the four defined bits are stored
            st_nxt.pend = {i_sfr.wdata[PEND_SEVEN_BIT], i_sfr.wdata[PEND_SIX_BIT]};
            st_nxt.pol = {i_sfr.wdata[POL_SEVEN_BIT], i_sfr.wdata[POL_SIX_BIT]};
         end
      end

      // Edge detection; a detected edge beats a clear in the same cycle
      for (int unsigned e = 0; e < 2; e++) begin
         pin_now = i_pin_in[PIN_EDGE_SIX + e];
         if (st_r.pol[e]) begin
            edge_seen = !st_r.prev[e] && pin_now;
         end else begin
            edge_seen = st_r.prev[e] && !pin_now;
         end
         if (edge_seen) begin
            st_nxt.pend[e] = 1'b1;
         end
         st_nxt.prev[e] = pin_now;
      end
      st_nxt.irq = st_nxt.pend;

      // Register readback
      if (i_sfr.rd) begin
         st_nxt.rdata = RDATA_RST;
         for (int unsigned k = 0; k < NUM_PORTS; k++) begin
            if (i_sfr.addr == port_addr(k)) begin
               if (i_sfr.rmw) begin
                  st_nxt.rdata = st_r.latch[k];
               end else begin
                  st_nxt.rdata = i_pin_in[k*PORT_W +: PORT_W];
               end
            end
         end
         if (i_sfr.addr == ADDR_TWO_DRIVE) begin
            st_nxt.rdata = st_r.two_drive;
         end else if (i_sfr.addr == ADDR_THREE_DRIVE) begin
            st_nxt.rdata = st_r.three_drive;
         end else if (i_sfr.addr == ADDR_NIB_DRIVE) begin
            st_nxt.rdata = st_r.nib_drive;
         end else if (i_sfr.addr == ADDR_EDGE_FLAGS) begin
            st_nxt.rdata[PEND_SEVEN_BIT] = st_r.pend[1];
            st_nxt.rdata[PEND_SIX_BIT] = st_r.pend[0];
            st_nxt.rdata[POL_SEVEN_BIT] = st_r.pol[1];
            st_nxt.rdata[POL_SIX_BIT] = st_r.pol[0];
         end
      end

      // Pin drivers, computed from the updated latches
      for (int unsigned k = 0; k < NUM_PORTS; k++) begin
         for (int unsigned b = 0; b < PORT_W; b++) begin
            p = k * PORT_W + b;
            val = st_nxt.latch[k][b];
            drv = 1'b1;
            if (i_external_memory_interface.active && k == PORT_TWO) begin
               if (i_external_memory_interface.muxed) begin
                  val = i_external_memory_interface.addr[EXTERNAL_MEMORY_INTERFACE_HIGH_BYTE + b];
               end else begin
                  val = i_external_memory_interface.addr[b];
               end
            end else if (i_external_memory_interface.active && k == PORT_THREE) begin
               val = i_external_memory_interface.data[b];
               drv = i_external_memory_interface.data_drive;
            end
            if (push_pull(st_nxt, k, b) && !i_force_open_drain[p]) begin
               st_nxt.pin_oe[p] = drv;
            end else begin
               st_nxt.pin_oe[p] = drv && !val;
            end
            st_nxt.pin_out[p] = val;
            st_nxt.pullup_en[p] = !i_pullup_global_disable
                                  && !(st_nxt.pin_oe[p] && !val);
         end
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         st_r.latch <= {NUM_PORTS{LATCH_RST}};
         st_r.two_drive <= DRIVE_RST;
         st_r.three_drive <= DRIVE_RST;
         st_r.nib_drive <= DRIVE_RST;
         st_r.pend <= PEND_RST;
         st_r.pol <= POL_RST;
         st_r.prev <= PREV_RST;
         st_r.irq <= PEND_RST;
         st_r.rdata <= RDATA_RST;
         st_r.pin_out <= {PIN_W{1'b1}};
         st_r.pin_oe <= '0;
         st_r.pullup_en <= {PIN_W{1'b1}};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_sfr_rdata = st_r.rdata;
   assign o_pin_out = st_r.pin_out;
   assign o_pin_oe = st_r.pin_oe;
   assign o_pullup_en = st_r.pullup_en;
   assign o_edge_irq = st_r.irq;

   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_sys_rst);

   a_latch_byte_write: assert property (
      byte_wr && i_sfr.addr == ADDR_PORT_TWO |=> st_r.latch[PORT_TWO] == $past(i_sfr.wdata))
      else $error("port two latch missed a byte write");

   a_pin_level_read: assert property (
      i_sfr.rd && !i_sfr.rmw && i_sfr.addr == ADDR_PORT_THREE
      |=> o_sfr_rdata == $past(i_pin_in[15:8]))
      else $error("port three read did not return pin levels");

   a_rmw_latch_read: assert property (
      i_sfr.rd && i_sfr.rmw && i_sfr.addr == ADDR_PORT_SEVEN
      |=> o_sfr_rdata == $past(st_r.latch[5]))
      else $error("read-modify-write did not return latch");

   a_push_pull_high: assert property (
      st_nxt.latch[PORT_TWO][0] && st_nxt.two_drive[0] && !i_force_open_drain[0]
      && !i_external_memory_interface.active |=> o_pin_oe[0] && o_pin_out[0])
      else $error("push-pull pin not driven high");

   a_open_drain_float: assert property (
      st_nxt.latch[PORT_TWO][1] && !st_nxt.two_drive[1] && !i_external_memory_interface.active
      |=> !o_pin_oe[1] && !o_pullup_en[1] == $past(i_pullup_global_disable))
      else $error("open-drain pin with latch one not released");

   a_low_drives_ground: assert property (
      !st_nxt.latch[3][2] |=> o_pin_oe[26] && !o_pin_out[26] && !o_pullup_en[26])
      else $error("latch zero did not drive low with pull-up off");

   a_forced_open_drain: assert property (
      i_force_open_drain[12] && st_nxt.latch[PORT_THREE][4] && !i_external_memory_interface.active
      |=> !o_pin_oe[12])
      else $error("forced open-drain pin driven high");

   a_falling_edge_flag: assert property (
      !st_r.pol[1] && st_r.prev[1] && !i_pin_in[PIN_EDGE_SEVEN]
      |=> st_r.pend[1] && o_edge_irq[1] ##1 o_edge_irq[1])
      else $error("falling edge on input seven not flagged");

   a_flag_holds: assert property (
      st_r.pend[0] && !(byte_wr && i_sfr.addr == ADDR_EDGE_FLAGS) |=> st_r.pend[0])
      else $error("pending flag six cleared without a write");

   a_rising_edge_flag: assert property (
      st_r.pol[0] && !st_r.prev[0] && i_pin_in[PIN_EDGE_SIX] |=> st_r.pend[0])
      else $error("rising edge on input six not flagged");

   a_unused_bits_zero: assert property (
      i_sfr.rd && i_sfr.addr == ADDR_EDGE_FLAGS
      |=> o_sfr_rdata[5:4] == 2'h0 && o_sfr_rdata[1:0] == 2'h0)
      else $error("unused flag bits read nonzero");

   a_nibble_push_pull: assert property (
      st_nxt.nib_drive[7] && st_nxt.latch[5][7] && !i_force_open_drain[47]
      |=> o_pin_oe[47] && o_pin_out[47])
      else $error("port seven upper nibble not push-pull");

   a_bit_write_refused: assert property (
      i_sfr.wr && i_sfr.bit_en && i_sfr.addr == ADDR_PORT_FOUR
      |=> st_r.latch[2] == $past(st_r.latch[2]))
      else $error("bit write changed port four latch");

   a_external_memory_interface_address_out: assert property (
      i_external_memory_interface.active && i_external_memory_interface.muxed |=> o_pin_out[7:0] == $past(i_external_memory_interface.addr[15:8]))
      else $error("port two not carrying high address");

   a_external_memory_interface_data_out: assert property (
      i_external_memory_interface.active && !i_external_memory_interface.data_drive |=> o_pin_oe[15:8] == 8'h00)
      else $error("port three driven during memory read");
endmodule

// file: test/pin_board_model.sv
// Board wiring model: resolves each pin from the device, an outside driver and pull-ups
module pin_board_model
   import gpio_pkg::*;
(
   // Clock
   input wire logic i_core_clk,
   // Device side drive
   input wire logic [PIN_W-1:0] i_drv_out,
   input wire logic [PIN_W-1:0] i_drv_oe,
   input wire logic [PIN_W-1:0] i_pullup_en,
   // Outside driver sharing the wire
   input wire logic [PIN_W-1:0] i_ext_val,
   input wire logic [PIN_W-1:0] i_ext_oe,
   // Resolved wire level
   output logic [PIN_W-1:0] o_level
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [PIN_W-1:0] last_r;

   always_ff @(posedge i_core_clk) begin
      last_r <= o_level;
   end

   // Shared wire is wired-and; an undriven wire without pull-up wanders
   always_comb begin
      for (int i = 0; i < PIN_W; i++) begin
         if (i_drv_oe[i] && i_ext_oe[i]) begin
            o_level[i] = i_drv_out[i] & i_ext_val[i];
         end else if (i_drv_oe[i]) begin
            o_level[i] = i_drv_out[i];
         end else if (i_ext_oe[i]) begin
            o_level[i] = i_ext_val[i];
         end else if (i_pullup_en[i]) begin
            o_level[i] = 1'b1;
         end else begin
            o_level[i] = ~last_r[i];
         end
      end
   end
endmodule

// file: test/port_io_block_tb.sv
// Self-checking bench for the port latch, drive mode and edge flag block
module port_io_block_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import gpio_pkg::*;

   logic i_core_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   sfr_req_s sfr = '0;
   external_memory_interface_s external_memory_interface = '0;
   logic pud = 1'b0;
   logic [PIN_W-1:0] fod = '0, ext_val = '0, ext_oe = '0;
   logic [PIN_W-1:0] lvl, pout, poe, pue;
   logic [7:0] rdata, v;
   logic [1:0] irq;
   logic rd_d = 1'b0;
   logic [7:0] exp_q[$];
   int error_cnt = 0, n_compared = 0, seed = 53918;

   always #25 i_core_clk = ~i_core_clk;

   port_io_block DUT (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_sfr(sfr),
      .o_sfr_rdata(rdata), .i_force_open_drain(fod), .i_pullup_global_disable(pud),
      .i_external_memory_interface(external_memory_interface), .i_pin_in(lvl), .o_pin_out(pout), .o_pin_oe(poe),
      .o_pullup_en(pue), .o_edge_irq(irq));

   pin_board_model board (.i_core_clk(i_core_clk), .i_drv_out(pout), .i_drv_oe(poe),
      .i_pullup_en(pue), .i_ext_val(ext_val), .i_ext_oe(ext_oe), .o_level(lvl));

   task automatic cmp_vec(input string nm, input logic [47:0] e, input logic [47:0] g);
      n_compared++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic cmp_rd(input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch read data expected %h seen %h", e, g);
      end
   endtask

   // Read results are taken from the queue in the cycle after the read strobe
   always @(posedge i_core_clk) rd_d <= sfr.rd;
   always @(negedge i_core_clk) begin
      if (rd_d) begin
         if (exp_q.size() == 0) cmp_rd(8'hxx, rdata);
         else cmp_rd(exp_q.pop_front(), rdata);
      end
   end

   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic b = 1'b0,
                     input logic [2:0] s = 3'h0);
      @(posedge i_core_clk);
      sfr <= '{a, 1'b1, 1'b0, 1'b0, b, s, d};
      @(posedge i_core_clk);
      sfr <= '0;
   endtask

   task automatic rd(input logic [7:0] a, input logic m, input logic [7:0] e);
      @(posedge i_core_clk);
      sfr <= '{a, 1'b0, 1'b1, m, 1'b0, 3'h0, 8'h00};
      exp_q.push_back(e);
      @(posedge i_core_clk);
      sfr <= '0;
   endtask

   task automatic settle();
      repeat (2) @(posedge i_core_clk);
      @(negedge i_core_clk);
   endtask

   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic wait_irq(input logic [1:0] e);
      for (int i = 0; i < 8 && irq !== e; i++) @(negedge i_core_clk);
      if (irq !== e) begin
         error_cnt++;
         $display("mismatch irq wait expected %h seen %h", e, irq);
         wrap_up();
      end else begin
         cmp_vec("irq", {46'h0, e}, {46'h0, irq});
      end
   endtask

   initial begin
      repeat (6) @(posedge i_core_clk);
      i_sys_rst <= 1'b0;
      @(negedge i_core_clk);
      cmp_vec("oe", '0, poe);
      cmp_vec("out", '1, pout);
      cmp_vec("pullup", '1, pue);
      rd(ADDR_PORT_TWO, 1'b0, 8'hFF);
      rd(ADDR_TWO_DRIVE, 1'b0, 8'h00);
      rd(ADDR_THREE_DRIVE, 1'b0, 8'h00);
      rd(ADDR_EDGE_FLAGS, 1'b0, 8'h00);
      rd(ADDR_NIB_DRIVE, 1'b0, 8'h00);
      rd(8'hAF, 1'b0, 8'h00);
      rd(ADDR_PORT_SEVEN, 1'b1, 8'hFF);
      $display("test reset done");
      wr(ADDR_PORT_TWO, 8'h55);
      settle();
      cmp_vec("oe two", 48'hAA, {40'h0, poe[7:0]});
      cmp_vec("out two", 48'h00, {40'h0, pout[7:0] & poe[7:0]});
      cmp_vec("pullup two", 48'h55, {40'h0, pue[7:0]});
      rd(ADDR_PORT_TWO, 1'b0, 8'h55);
      wr(ADDR_TWO_DRIVE, 8'hFF);
      settle();
      cmp_vec("pp oe", 48'hFF, {40'h0, poe[7:0]});
      cmp_vec("pp out", 48'h55, {40'h0, pout[7:0]});
      @(posedge i_core_clk);
      fod <= 48'h1;
      settle();
      cmp_vec("forced", 48'hFE, {40'h0, poe[7:0]});
      @(posedge i_core_clk);
      fod <= '0;
      pud <= 1'b1;
      settle();
      cmp_vec("pull off", 48'h00, {40'h0, pue[7:0]});
      @(posedge i_core_clk);
      pud <= 1'b0;
      for (int k = 0; k < 4; k++) begin
         v = 8'($random(seed));
         wr(ADDR_PORT_TWO, v);
         settle();
         cmp_vec("rand out", {40'h0, v}, {40'h0, pout[7:0]});
         rd(ADDR_PORT_TWO, 1'b1, v);
      end
      wr(ADDR_PORT_TWO, 8'h00, 1'b1, 3'h3);
      rd(ADDR_PORT_TWO, 1'b1, v & 8'hF7);
      wr(ADDR_PORT_FOUR, 8'h00, 1'b1, 3'h0);
      rd(ADDR_PORT_FOUR, 1'b1, 8'hFF);
      $display("test drive done");
      // Port three stays open-drain with latch ones, so it acts as input
      @(posedge i_core_clk);
      ext_oe <= {8'hFF, 24'h00_0000, 8'h3F, 8'h00};
      ext_val <= {8'h5A, 24'h00_0000, 8'h0A, 8'h00};
      rd(ADDR_PORT_THREE, 1'b0, 8'hCA);
      rd(ADDR_PORT_THREE, 1'b1, 8'hFF);
      rd(ADDR_PORT_SEVEN, 1'b0, 8'h5A);
      @(posedge i_core_clk);
      ext_oe <= '0;
      $display("test readback done");
      for (int k = 0; k < 8; k++) begin
         wr(ADDR_NIB_DRIVE, 8'h01 << k);
         settle();
         cmp_vec("nibble oe", {16'h0, 32'hF << (4 * k)}, {16'h0, poe[47:16]});
      end
      wr(ADDR_NIB_DRIVE, 8'hFF);
      settle();
      cmp_vec("all nibbles", {16'h0, 32'hFFFF_FFFF}, {16'h0, poe[47:16]});
      wr(ADDR_PORT_FIVE, 8'h00);
      settle();
      cmp_vec("upper out", {16'h0, 32'hFFFF_00FF}, {16'h0, pout[47:16]});
      cmp_vec("upper pullup", 48'h00, {40'h0, pue[31:24]});
      $display("test nibble done");
      // Floating pins during the pull-up test may have set the flags
      wr(ADDR_EDGE_FLAGS, 8'h00);
      wait_irq(2'b00);
      @(posedge i_core_clk);
      ext_oe <= 48'h0000_0000_C000;
      ext_val <= '0;
      wait_irq(2'b11);
      rd(ADDR_EDGE_FLAGS, 1'b0, 8'hC0);
      wr(ADDR_EDGE_FLAGS, 8'h3C);
      wait_irq(2'b00);
      rd(ADDR_EDGE_FLAGS, 1'b0, 8'h0C);
      @(posedge i_core_clk);
      ext_oe <= '0;
      wait_irq(2'b11);
      rd(ADDR_EDGE_FLAGS, 1'b0, 8'hCC);
      repeat (4) @(negedge i_core_clk);
      cmp_vec("irq held", 48'h3, {46'h0, irq});
      $display("test edge done");
      wr(ADDR_THREE_DRIVE, 8'hFF);
      @(posedge i_core_clk);
      external_memory_interface <= '{1'b1, 1'b1, 1'b1, 16'hA5C3, 8'h3E};
      settle();
      cmp_vec("external_memory_interface muxed", 48'hA5, {40'h0, pout[7:0]});
      @(posedge i_core_clk);
      external_memory_interface <= '{1'b1, 1'b0, 1'b1, 16'hA5C3, 8'h3E};
      settle();
      cmp_vec("external_memory_interface addr", 48'hC3, {40'h0, pout[7:0]});
      cmp_vec("external_memory_interface data", 48'h3E, {40'h0, pout[15:8]});
      @(posedge i_core_clk);
      external_memory_interface <= '{1'b1, 1'b0, 1'b0, 16'hA5C3, 8'h3E};
      settle();
      cmp_vec("external_memory_interface release", 48'h00, {40'h0, poe[15:8]});
      @(posedge i_core_clk);
      external_memory_interface <= '0;
      @(posedge i_core_clk);
      fod <= 48'h0000_0000_1000;
      settle();
      cmp_vec("forced three", 48'hEF, {40'h0, poe[15:8]});
      $display("test external_memory_interface done");
      repeat (3) @(posedge i_core_clk);
      if (exp_q.size() != 0) begin
         error_cnt++;
         $display("mismatch read queue expected 0 seen %0d", exp_q.size());
      end
      wrap_up();
   end
endmodule
